// >>> core/cid_cfg.svh
// Constants for the caller identity function select block
`ifndef CID_CFG_SVH
`define CID_CFG_SVH

// Clock rate
`define CID_CLK_HZ 125000000
// Alert-detect strobe low time, in microseconds
`define CID_ALERT_LOW_US 416
`define CID_ALERT_LOW_CYCLES ((`CID_ALERT_LOW_US * (`CID_CLK_HZ / 1000000)))
// Default serial bit rate (bits per second) used for the word-ready half bit
`define CID_BIT_RATE 1200
`define CID_HALF_BIT_CYCLES (`CID_CLK_HZ / (2 * `CID_BIT_RATE))
// Byte buffer length: data byte plus stop bit
`define CID_BUF_BITS 9
// Strobe idle level
`define CID_STROBE_IDLE 1'b1

`endif

// >>> core/cid_pkg.sv
// Types for the caller identity function select block
package cid_pkg;

    typedef enum logic [2:0] {
        FN_FSK = 3'b000,
        FN_OFFHOOK = 3'b001,
        FN_ONHOOK = 3'b010,
        FN_POWERDOWN = 3'b011,
        FN_TEST = 3'b100
    } func_type;

endpackage

// >>> core/caller_id_function_select.sv
// Function select, amplifier routing, strobe and serial output of a caller identity receiver
//
// Summary of operation
// - Both function selects high: FSK on line amp, strobe is word-ready.
// - A high, B low: off-hook alert detect on hybrid amp, strobe is alert-detect.
// - A low, B high: on-hook alert detect on line amp, strobe is alert-detect.
// - Interface select high, both selects low: power-down, all off, strobe high.
// - In power-down the shift clock pin is an input (buffered mode).
// - Hybrid amp is used only for off-hook alert detect, ignored otherwise.
// - Interface select low: direct bit stream; high: 9-bit buffer read by clock.
// - Word-ready rests high, pulses low at each word end for half a bit time, or until the first read clock if buffered.
// - Alert-detect goes low for 416 us after a detected alert tone ends.
`include "cid_cfg.svh"

module caller_id_function_select
    import cid_pkg::*;
#(
    parameter int SAMPLE_W = 12,
    parameter int HALF_BIT_CYCLES = `CID_HALF_BIT_CYCLES,
    parameter int ALERT_CYCLES = `CID_ALERT_LOW_CYCLES
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Select pins
    input wire logic interface_select_pin,
    input wire logic function_select_a,
    input wire logic function_select_b,
    // Amplifier samples
    input wire logic [SAMPLE_W-1:0] line_side_amp,
    input wire logic [SAMPLE_W-1:0] hybrid_side_amp,
    // Demodulator and detector events
    input wire logic demod_bit,
    input wire logic demod_bit_strobe,
    input wire logic word_valid,
    input wire logic [`CID_BUF_BITS-1:0] word_data,
    input wire logic alert_tone_end,
    // Shift clock pin
    input wire logic shift_clock_in,
    output logic shift_clock_out,
    output logic shift_clock_oe,
    // Detector input and enables
    output logic [SAMPLE_W-1:0] detector_sample,
    output logic sel_hybrid,
    output logic fsk_enable,
    output logic offhook_detect_enable,
    output logic onhook_detect_enable,
    // Serial data and shared strobe
    output logic data_out,
    output logic shared_strobe_n
);

    // The shared pulse counter is 20 bits wide, so longer pulses are refused when the block is built
    if (SAMPLE_W < 1 || HALF_BIT_CYCLES < 1 || ALERT_CYCLES < 1 || HALF_BIT_CYCLES >= (1 << 20)
        || ALERT_CYCLES >= (1 << 20)) begin : g_bad_params
        $error("caller_id_function_select: unsupported parameter values");
    end

    localparam logic [19:0] HALF_BIT_LOAD = 20'(HALF_BIT_CYCLES);
    localparam logic [19:0] ALERT_LOAD = 20'(ALERT_CYCLES);

    func_type func;
    func_type func_prev;
    logic [`CID_BUF_BITS-1:0] buffer;
    logic [19:0] strobe_count;
    logic shift_clock_prev;
    logic shift_rise;
    logic buffered;

    ////////////////////////////////////////////////////////////////////////////////
    // Select decode, purely combinational so a pin change acts at once
    always_comb begin
        case ({interface_select_pin, function_select_a, function_select_b})
            3'b011, 3'b111: func = FN_FSK;
            3'b010, 3'b110: func = FN_OFFHOOK;
            3'b001, 3'b101: func = FN_ONHOOK;
            3'b100: func = FN_POWERDOWN;
            // Reserved test code: treated as everything off
            default: func = FN_TEST;
        endcase
    end

    assign buffered = interface_select_pin;
    assign shift_rise = shift_clock_in && !shift_clock_prev;

    ////////////////////////////////////////////////////////////////////////////////
    // Routing and enables
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            fsk_enable <= 1'b0;
            offhook_detect_enable <= 1'b0;
            onhook_detect_enable <= 1'b0;
            sel_hybrid <= 1'b0;
            detector_sample <= '0;
        end else begin
            fsk_enable <= (func == FN_FSK);
            offhook_detect_enable <= (func == FN_OFFHOOK);
            onhook_detect_enable <= (func == FN_ONHOOK);
            sel_hybrid <= (func == FN_OFFHOOK);
            case (func)
                FN_OFFHOOK: detector_sample <= hybrid_side_amp;
                FN_FSK, FN_ONHOOK: detector_sample <= line_side_amp;
                default: detector_sample <= '0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Shift clock pin: driven only in direct mode, an input whenever buffered
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            shift_clock_prev <= 1'b0;
            shift_clock_out <= 1'b0;
            shift_clock_oe <= 1'b0;
        end else begin
            shift_clock_prev <= shift_clock_in;
            shift_clock_out <= demod_bit_strobe && (func == FN_FSK);
            shift_clock_oe <= !buffered && (func == FN_FSK);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Serial data: direct stream or 9-bit buffer shifted out LSB first
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            buffer <= '0;
            data_out <= 1'b0;
        end else if (func != FN_FSK) begin
            data_out <= 1'b0;
        end else if (!buffered) begin
            data_out <= demod_bit;
        end else if (word_valid) begin
            buffer <= word_data;
            data_out <= word_data[0];
        end else if (shift_rise) begin
            buffer <= {1'b1, buffer[`CID_BUF_BITS-1:1]};
            data_out <= buffer[1];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Shared strobe; a function change drops any pulse in progress
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            func_prev <= FN_TEST;
            strobe_count <= '0;
            shared_strobe_n <= `CID_STROBE_IDLE;
        end else begin
            func_prev <= func;
            if (func != func_prev || func == FN_POWERDOWN || func == FN_TEST) begin
                strobe_count <= '0;
                shared_strobe_n <= `CID_STROBE_IDLE;
            end else if (func == FN_FSK && word_valid) begin
                strobe_count <= HALF_BIT_LOAD - 20'd1;
                shared_strobe_n <= 1'b0;
            end else if ((func == FN_OFFHOOK || func == FN_ONHOOK) && alert_tone_end) begin
                strobe_count <= ALERT_LOAD - 20'd1;
                shared_strobe_n <= 1'b0;
            end else if (func == FN_FSK && buffered && shift_rise && !shared_strobe_n) begin
                // First read clock returns the strobe high so it can clear an interrupt
                strobe_count <= '0;
                shared_strobe_n <= `CID_STROBE_IDLE;
            end else if (strobe_count != 20'd0) begin
                strobe_count <= strobe_count - 20'd1;
            end else begin
                shared_strobe_n <= `CID_STROBE_IDLE;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    sequence word_start_seq;
        (func == FN_FSK) && (func_prev == FN_FSK) && word_valid;
    endsequence

    sequence alert_start_seq;
        (func == FN_OFFHOOK || func == FN_ONHOOK) && (func_prev == func) && alert_tone_end;
    endsequence

    chk_powerdown_strobe_high: assert property (@(posedge mclk) disable iff (!nrst)
        (func == FN_POWERDOWN) [*2] |-> shared_strobe_n && !fsk_enable && !onhook_detect_enable)
        else $error("strobe not high in power-down");

    chk_powerdown_clock_input: assert property (@(posedge mclk) disable iff (!nrst)
        buffered |=> !shift_clock_oe)
        else $error("shift clock driven in buffered mode");

    chk_hybrid_only_offhook: assert property (@(posedge mclk) disable iff (!nrst)
        sel_hybrid |-> $past(func) == FN_OFFHOOK)
        else $error("hybrid amp selected outside off-hook detect");

    chk_fsk_line_route: assert property (@(posedge mclk) disable iff (!nrst)
        (func == FN_FSK) |=> fsk_enable && detector_sample == $past(line_side_amp))
        else $error("FSK not routed from line amp");

    chk_offhook_route: assert property (@(posedge mclk) disable iff (!nrst)
        (func == FN_OFFHOOK) |=> offhook_detect_enable && detector_sample == $past(hybrid_side_amp))
        else $error("off-hook detect not routed from hybrid amp");

    chk_onhook_route: assert property (@(posedge mclk) disable iff (!nrst)
        (func == FN_ONHOOK) |=> onhook_detect_enable && !sel_hybrid && detector_sample == $past(line_side_amp))
        else $error("on-hook detect not routed from line amp");

    chk_word_ready_low: assert property (@(posedge mclk) disable iff (!nrst)
        word_start_seq |=> !shared_strobe_n && strobe_count == HALF_BIT_LOAD - 20'd1)
        else $error("word-ready pulse not started");

    chk_alert_low: assert property (@(posedge mclk) disable iff (!nrst)
        alert_start_seq |=> !shared_strobe_n && strobe_count == ALERT_LOAD - 20'd1)
        else $error("alert-detect pulse not started");

    chk_direct_stream: assert property (@(posedge mclk) disable iff (!nrst)
        (func == FN_FSK && !buffered) |=> data_out == $past(demod_bit))
        else $error("direct mode data not passed through");

    chk_buffer_shift: assert property (@(posedge mclk) disable iff (!nrst)
        (func == FN_FSK && buffered && shift_rise && !word_valid) |=> data_out == $past(buffer[1]))
        else $error("buffered data not shifted on read clock");

endmodule

// >>> tb/host_model.sv
// Host controller model driving the select pins and the shift clock
module host_model (
    // Clock
    input wire logic mclk,
    // Bench requests
    input wire logic [2:0] req,
    input wire logic offhook,
    input wire logic rd,
    // Device pins
    output logic interface_select_pin,
    output logic function_select_a,
    output logic function_select_b,
    output logic shift_clock_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] code;
    logic [2:0] code_seen;
    logic rd_seen;
    always_comb begin
        code = req;
        if (req[1:0] == 2'h0) code = 3'h4;
        if (req[1:0] == 2'h1 && offhook) code = {req[2], 2'h2};
    end
    // Start in power-down so the reserved code never appears
    // Requests are taken at the edge, before the bench moves them, so the pins lag by one cycle
    initial begin
        {interface_select_pin, function_select_a, function_select_b, shift_clock_in} = 4'h8;
        forever begin
            @(posedge mclk);
            code_seen = code;
            rd_seen = rd;
            #1;
            {interface_select_pin, function_select_a, function_select_b} = code_seen;
            shift_clock_in = rd_seen;
        end
    end
endmodule

// >>> tb/tb_caller_id_function_select.sv
// Self-checking bench for the function select block
module tb_caller_id_function_select;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HALF = 8;
    localparam int ALERT = 10;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic cb0, fa, fb, sci, offhook, rd, demod_bit, demod_bit_strobe, word_valid, alert_tone_end, b;
    logic [2:0] req;
    logic [11:0] la, ha, ds;
    logic [8:0] word_data;
    logic [4:0] e;
    logic sco, soe, sh, fe, offe, one, dout, strobe_n;
    int seed = 28;
    int n_errors = 0;
    int n_checks = 0;
    int n;
    always #4 mclk = ~mclk;
    host_model i_host_model (.mclk(mclk), .req(req), .offhook(offhook), .rd(rd), .interface_select_pin(cb0),
        .function_select_a(fa), .function_select_b(fb), .shift_clock_in(sci));
    caller_id_function_select #(.HALF_BIT_CYCLES(HALF), .ALERT_CYCLES(ALERT)) i_caller_id_function_select (
        .mclk(mclk), .nrst(nrst), .interface_select_pin(cb0), .function_select_a(fa), .function_select_b(fb),
        .line_side_amp(la), .hybrid_side_amp(ha), .demod_bit(demod_bit), .demod_bit_strobe(demod_bit_strobe),
        .word_valid(word_valid), .word_data(word_data), .alert_tone_end(alert_tone_end), .shift_clock_in(sci),
        .shift_clock_out(sco), .shift_clock_oe(soe), .detector_sample(ds), .sel_hybrid(sh), .fsk_enable(fe),
        .offhook_detect_enable(offe), .onhook_detect_enable(one), .data_out(dout), .shared_strobe_n(strobe_n));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic cyc(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim;
        $display("errors %0d checks %0d", n_errors, n_checks);
        if (n_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Pins pass through the host model, so allow a few cycles to settle
    task automatic setf(input logic [2:0] c);
        req = c;
        cyc(4);
    endtask
    task automatic pulse(input logic alert);
        if (alert) alert_tone_end = 1'b1;
        else word_valid = 1'b1;
        cyc(1);
        alert_tone_end = 1'b0;
        word_valid = 1'b0;
    endtask
    task automatic low_len(output int k);
        k = 0;
        while (strobe_n === 1'b0 && k < 100) begin
            k++;
            cyc(1);
        end
        if (k == 100) begin
            n_errors++;
            end_sim;
        end
    endtask
    // Expected {fsk, offhook, onhook, hybrid select, shift clock drive}
    function automatic logic [4:0] expf(input logic [2:0] c);
        return {c[1] & c[0], c[1] & ~c[0], ~c[1] & c[0], c[1] & ~c[0], c[1] & c[0] & ~c[2]};
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {offhook, rd, demod_bit, demod_bit_strobe, word_valid, alert_tone_end} = 6'h00;
        req = 3'h4;
        la = 12'h000;
        ha = 12'h000;
        word_data = 9'h000;
        cyc(12);
        chk({strobe_n, fe, offe, one}, 16'h0008);
        nrst = 1'b1;
        cyc(2);
        for (int i = 1; i < 8; i++) begin
            la = 12'($random(seed));
            ha = 12'($random(seed));
            setf(i[2:0]);
            e = expf(i[2:0]);
            chk({fe, offe, one, sh, soe}, e);
            chk(ds, e[3] ? ha : ((e[4] | e[2]) ? la : 12'h000));
            chk(strobe_n, 1'b1);
        end
        offhook = 1'b1;
        setf(3'h1);
        chk({offe, one}, 2'h2);
        offhook = 1'b0;
        setf(3'h1);
        pulse(1'b1);
        low_len(n);
        chk(n >= ALERT && n <= ALERT + 1, 1'b1);
        setf(3'h2);
        pulse(1'b0);
        cyc(2);
        chk(strobe_n, 1'b1);
        pulse(1'b1);
        chk(strobe_n, 1'b0);
        setf(3'h3);
        chk(strobe_n, 1'b1);
        for (int i = 0; i < 6; i++) begin
            demod_bit = 1'($random(seed));
            demod_bit_strobe = 1'($random(seed));
            b = demod_bit;
            cyc(1);
            chk({dout, sco}, {b, demod_bit_strobe});
        end
        pulse(1'b0);
        low_len(n);
        chk(n >= HALF && n <= HALF + 1, 1'b1);
        setf(3'h7);
        word_data = 9'($random(seed));
        pulse(1'b0);
        chk({strobe_n, dout}, {1'b0, word_data[0]});
        for (int i = 1; i < 10; i++) begin
            rd = 1'b1;
            cyc(2);
            chk({strobe_n, dout}, {1'b1, (i < 9) ? word_data[i] : 1'b1});
            rd = 1'b0;
            cyc(2);
        end
        end_sim;
    end
endmodule
